// [hdl/pcei_edge.sv]
// Pin synchroniser and edge detector for the monitored port.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ps
`include "pcei_params.svh"

module pcei_edge
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [`PCEI_PINS-1:0]  pin_i,
  output logic      [`PCEI_PINS-1:0]  rise_o,
  output logic      [`PCEI_PINS-1:0]  fall_o
);

  logic [`PCEI_PINS-1:0] meta;
  logic [`PCEI_PINS-1:0] sync;
  logic [`PCEI_PINS-1:0] prev;

  // ---------------------------------------------------------------------------
  // Per-pin detector
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PCEI_PINS; g = g + 1)
    begin : g_pin
      logic next_meta;
      logic next_sync;
      logic next_prev;

      // The second and third stages feed the edge compare; the first stage only feeds the second
      always_comb
      begin
        next_meta = pin_i[g];
        next_sync = meta[g];
        next_prev = sync[g];
      end

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          meta[g] <= 1'b0;
          sync[g] <= 1'b0;
          prev[g] <= 1'b0;
        end
        else
        begin
          meta[g] <= next_meta;
          sync[g] <= next_sync;
          prev[g] <= next_prev;
        end
      end

      // Compare current and previous sample
      assign rise_o[g] = sync[g] & ~prev[g];
      assign fall_o[g] = ~sync[g] & prev[g];
    end
  endgenerate

endmodule

// [hdl/pcei_top.sv]
// Pin edge-change interrupt block with its register port.
// Assumes a single-cycle register master on clk_i and async port pins.
`timescale 1ns/1ps
`include "pcei_params.svh"

module pcei_top
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [`PCEI_PINS-1:0]  port_pin_i,
  input  wire logic [`PCEI_AW-1:0]    addr_i,
  input  wire logic [`PCEI_DW-1:0]    wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [`PCEI_DW-1:0]    rdata_o,
  output logic                        irq_o,
  output logic                        sleep_o,
  output logic                        wake_o
);

  // ---------------------------------------------------------------------------
  // Decode helper
  // ---------------------------------------------------------------------------
  function automatic logic hit
  (
    input logic              strobe,
    input logic [`PCEI_AW-1:0] a,
    input logic [`PCEI_AW-1:0] ofs
  );
    hit = strobe && (a == ofs);
  endfunction

  // ---------------------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------------------
  pcei_pkg::pcei_pins_t rise;
  pcei_pkg::pcei_pins_t fall;
  pcei_pkg::pcei_pins_t ev;

  pcei_edge u_edge
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (port_pin_i),
    .rise_o (rise),
    .fall_o (fall)
  );

  // ---------------------------------------------------------------------------
  // Configuration and flags
  // ---------------------------------------------------------------------------
  logic                 master_en;
  pcei_pkg::pcei_pins_t rise_en;
  pcei_pkg::pcei_pins_t fall_en;
  pcei_pkg::pcei_pins_t flag;
  logic [1:0]           stat;
  logic [1:0]           mask;
  logic                 next_master_en;
  pcei_pkg::pcei_pins_t next_rise_en;
  pcei_pkg::pcei_pins_t next_fall_en;
  pcei_pkg::pcei_pins_t next_flag;
  logic [1:0]           next_stat;
  logic [1:0]           next_mask;
  logic                 summary;
  logic                 waking;

  // Each detector has its own enable; both may be armed together
  assign ev      = (rise & rise_en) | (fall & fall_en);
  assign summary = |flag;

  // Register writes, with hardware sets winning over software clears
  always_comb
  begin
    next_master_en = master_en;
    next_rise_en   = rise_en;
    next_fall_en   = fall_en;
    next_mask      = mask;
    next_flag      = flag;
    next_stat      = stat;
    if (hit(wr_i, addr_i, `PCEI_OFS_CTRL))
      next_master_en = wdata_i[`PCEI_CTRL_MEN];
    if (hit(wr_i, addr_i, `PCEI_OFS_RISE))
      next_rise_en = wdata_i;
    if (hit(wr_i, addr_i, `PCEI_OFS_FALL))
      next_fall_en = wdata_i;
    if (hit(wr_i, addr_i, `PCEI_OFS_MASK))
      next_mask = wdata_i[1:0];
    // Writing one leaves a flag alone, so only zeros clear
    if (hit(wr_i, addr_i, `PCEI_OFS_FLAG))
      next_flag = flag & wdata_i;
    next_flag = next_flag | ev;
    // Status is cleared by reading it; a new event in that cycle survives
    if (hit(rd_i, addr_i, `PCEI_OFS_STAT))
      next_stat = `PCEI_RST_STAT;
    next_stat[`PCEI_STAT_EDGE] = next_stat[`PCEI_STAT_EDGE] | (|ev);
    next_stat[`PCEI_STAT_WAKE] = next_stat[`PCEI_STAT_WAKE] | waking;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      master_en <= 1'b0;
      rise_en   <= `PCEI_RST_BYTE;
      fall_en   <= `PCEI_RST_BYTE;
      flag      <= `PCEI_RST_BYTE;
      stat      <= `PCEI_RST_STAT;
      mask      <= `PCEI_RST_STAT;
    end
    else
    begin
      master_en <= next_master_en;
      rise_en   <= next_rise_en;
      fall_en   <= next_fall_en;
      flag      <= next_flag;
      stat      <= next_stat;
      mask      <= next_mask;
    end
  end

  // ---------------------------------------------------------------------------
  // Sleep and wake-up
  // ---------------------------------------------------------------------------
  pcei_pkg::pcei_pwr_t pwr;
  pcei_pkg::pcei_pwr_t next_pwr;
  logic                next_wake;

  // Flags load on the same edge that leaves sleep, so they are ready first
  assign waking = (pwr == pcei_pkg::PCEI_SLEEP) && master_en && (|ev);

  always_comb
  begin
    next_pwr  = pwr;
    next_wake = 1'b0;
    unique case (pwr)
      pcei_pkg::PCEI_RUN:
      begin
        if (hit(wr_i, addr_i, `PCEI_OFS_CTRL) && wdata_i[`PCEI_CTRL_SLP])
          next_pwr = pcei_pkg::PCEI_SLEEP;
      end
      pcei_pkg::PCEI_SLEEP:
      begin
        if (waking)
        begin
          next_pwr  = pcei_pkg::PCEI_RUN;
          next_wake = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwr    <= pcei_pkg::PCEI_RUN;
      wake_o <= 1'b0;
    end
    else
    begin
      pwr    <= next_pwr;
      wake_o <= next_wake;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data, interrupt and sleep outputs
  // ---------------------------------------------------------------------------
  logic [`PCEI_DW-1:0] next_rdata;
  logic                next_irq;

  // Read data only stand in the cycle after the strobe
  always_comb
  begin
    next_rdata = `PCEI_RST_BYTE;
    if (rd_i)
    begin
      unique case (addr_i)
        `PCEI_OFS_CTRL:
        begin
          next_rdata[`PCEI_CTRL_MEN] = master_en;
          next_rdata[`PCEI_CTRL_SUM] = summary;
          next_rdata[`PCEI_CTRL_SLP] = (pwr == pcei_pkg::PCEI_SLEEP);
        end
        `PCEI_OFS_RISE: next_rdata = rise_en;
        `PCEI_OFS_FALL: next_rdata = fall_en;
        `PCEI_OFS_FLAG: next_rdata = flag;
        `PCEI_OFS_STAT: next_rdata[1:0] = stat;
        `PCEI_OFS_MASK: next_rdata[1:0] = mask;
        default:        next_rdata = `PCEI_RST_BYTE;
      endcase
    end
  end

  // Master enable gates every interrupt; uses the next values to save a cycle
  always_comb
  begin
    next_irq = next_master_en && (|(next_stat & next_mask));
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= `PCEI_RST_BYTE;
      irq_o   <= 1'b0;
      sleep_o <= 1'b0;
    end
    else
    begin
      rdata_o <= next_rdata;
      irq_o   <= next_irq;
      sleep_o <= (next_pwr == pcei_pkg::PCEI_SLEEP);
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic flag_wr;
  assign flag_wr = hit(wr_i, addr_i, `PCEI_OFS_FLAG);

  property p_rise_sets;
    ((rise & rise_en) != 0) |=> ((flag & $past(rise & rise_en)) == $past(rise & rise_en));
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

  property p_both_dirs;
    ((rise_en & fall_en & fall) != 0) |=> ((flag & $past(fall)) != 0);
  endproperty
  a_both_dirs: assert property (p_both_dirs) else $error("falling edge lost");

  property p_fall_sets;
    ((fall & fall_en) != 0) |=> ((flag & $past(fall & fall_en)) == $past(fall & fall_en));
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge not flagged");

  property p_irq_on;
    (master_en && ((stat & mask) != 2'h0)) |-> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

  property p_irq_gate;
    !master_en |-> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without master enable");

  property p_no_irq_off;
    (!master_en && (ev != 0) && !hit(wr_i, addr_i, `PCEI_OFS_CTRL)) |=> (flag != 0) && !irq_o;
  endproperty
  a_no_irq_off: assert property (p_no_irq_off) else $error("irq while disabled");

  property p_summary;
    hit(rd_i, addr_i, `PCEI_OFS_CTRL) |=> (rdata_o[`PCEI_CTRL_SUM] == $past(|flag));
  endproperty
  a_summary: assert property (p_summary) else $error("summary mismatch");

  property p_clear_collide;
    (flag_wr && (ev != 0)) |=> ((flag & $past(ev)) == $past(ev));
  endproperty
  a_clear_collide: assert property (p_clear_collide) else $error("edge lost on clear");

  property p_wake;
    (pwr == pcei_pkg::PCEI_SLEEP && master_en && ev != 0) |=> wake_o ##1 !wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake-up");

  property p_no_wake_off;
    (pwr == pcei_pkg::PCEI_SLEEP && !master_en) |=> !wake_o;
  endproperty
  a_no_wake_off: assert property (p_no_wake_off) else $error("wake while disabled");

  property p_wake_flag;
    wake_o |-> ((flag & $past(ev)) == $past(ev));
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("waking edge not flagged");

  property p_flag_at_wake;
    wake_o |-> (flag != 0) && !sleep_o;
  endproperty
  a_flag_at_wake: assert property (p_flag_at_wake) else $error("flag late at wake");

  property p_stable;
    (!flag_wr && ev == 0) |=> (flag == $past(flag));
  endproperty
  a_stable: assert property (p_stable) else $error("flag changed alone");

  property p_excl;
    (rise & fall) == 0;
  endproperty
  a_excl: assert property (p_excl) else $error("rise and fall together");

  // Two synchroniser flops, then a compare with the sample before; skip edges that saw reset
  property p_rise_edge;
    (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3))
      |-> (rise == ($past(port_pin_i, 2) & ~$past(port_pin_i, 3)));
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rise detector wrong");

  property p_fall_edge;
    (!$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3))
      |-> (fall == (~$past(port_pin_i, 2) & $past(port_pin_i, 3)));
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("fall detector wrong");

  c_collide:  cover property (flag_wr && ev != 0);
  c_disabled: cover property (!master_en && ev != 0);
  c_wake:     cover property (wake_o);
  c_irq:      cover property (irq_o);
  c_both:     cover property ((rise_en & fall_en & (rise | fall)) != 0);

endmodule

// [shared/pcei_params.svh]
// Constants for the pin edge-change interrupt block.
// Assumes one 125 MHz clock and an 8-pin monitored port.
`ifndef PCEI_PARAMS_SVH
`define PCEI_PARAMS_SVH

// -----------------------------------------------------------------------------
// Widths
// -----------------------------------------------------------------------------
`define PCEI_PINS      8
`define PCEI_AW        4
`define PCEI_DW        8

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define PCEI_OFS_CTRL  4'h0
`define PCEI_OFS_RISE  4'h1
`define PCEI_OFS_FALL  4'h2
`define PCEI_OFS_FLAG  4'h3
`define PCEI_OFS_STAT  4'h4
`define PCEI_OFS_MASK  4'h5

// -----------------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------------
`define PCEI_CTRL_MEN  0
`define PCEI_CTRL_SUM  1
`define PCEI_CTRL_SLP  2
`define PCEI_STAT_EDGE 0
`define PCEI_STAT_WAKE 1
`define PCEI_RST_BYTE  8'h00
`define PCEI_RST_STAT  2'h0

`endif

// [shared/pcei_pkg.sv]
// Types for the pin edge-change interrupt block.
// Assumes the constants header is included where the widths are needed.
`include "pcei_params.svh"

package pcei_pkg;

  // Power state: one bit, so Gray by construction
  typedef enum logic [0:0]
  {
    PCEI_RUN   = 1'b0,
    PCEI_SLEEP = 1'b1
  } pcei_pwr_t;

  typedef logic [`PCEI_PINS-1:0] pcei_pins_t;

endpackage

// [test/pcei_pin_model.sv]
// Behavioural model of the circuit driving the monitored port pins.
// Assumes the bench gives the wanted pin levels and a settle delay in clocks.
`timescale 1ns/1ps

module pcei_pin_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] want_i,
  input  wire logic [3:0] dly_i,
  output logic      [7:0] port_pin_o
);
  logic [3:0] wait_cnt;

  // -------------------------------------------------------------------------
  // Pin driver
  // -------------------------------------------------------------------------
  initial
  begin
    port_pin_o = 8'h00;
    wait_cnt   = 4'h0;
  end

  // A slow driver lags the request by dly_i plus one clocks; levels are always driven
  always @(posedge clk_i)
  begin
    if (port_pin_o == want_i)
      wait_cnt <= 4'h0;
    else if (wait_cnt >= dly_i)
      port_pin_o <= want_i;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

// [test/pin_edge_change_interrupt_test.sv]
// Self-checking bench for the pin edge-change interrupt block.
// Assumes a single-cycle register master and the pin driver model.
`timescale 1ns/1ps
`include "pcei_params.svh"

module pin_edge_change_interrupt_test;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] want  = 8'h00;
  logic [3:0] dly   = 4'h0;
  logic [3:0] addr  = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  wire  [7:0] pins;
  wire  [7:0] rdata;
  wire        irq;
  wire        slp;
  wire        wake;
  int         failures  = 0;
  int         cmp_count = 0;
  logic [31:0] seed = 32'h00009251;
  logic [7:0] re, fe, flg, nw, e, d;
  logic       men, st;

  // -------------------------------------------------------------------------
  // Clock, design and pin driver
  // -------------------------------------------------------------------------
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  pcei_top uut
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .port_pin_i (pins),
    .addr_i     (addr),
    .wdata_i    (wdata),
    .wr_i       (wr),
    .rd_i       (rd),
    .rdata_o    (rdata),
    .irq_o      (irq),
    .sleep_o    (slp),
    .wake_o     (wake)
  );

  pcei_pin_model drv
  (
    .clk_i      (clk_i),
    .want_i     (want),
    .dly_i      (dly),
    .port_pin_o (pins)
  );

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Enabled edges between two settled pin levels
  function automatic logic [7:0] edges(input logic [7:0] o, n, r, f);
    return ((~o & n) & r) | ((o & ~n) & f);
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic settle();
    repeat (12) @(posedge clk_i);
    #1;
  endtask

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, unmapped place reads zero
    for (int a = 0; a < 7; a++)
    begin
      rreg(a[3:0], d);
      chk(d, 8'h00);
    end
    rreg(4'hB, d);
    chk(d, 8'h00);
    flg = 8'h00;
    st  = 1'b0;
    // Random enables, master enable and pin moves, prompt and slow driver
    for (int i = 0; i < 24; i++)
    begin
      re  = 8'(rnd());
      fe  = 8'(rnd());
      men = 1'(rnd());
      wreg(`PCEI_OFS_RISE, re);
      wreg(`PCEI_OFS_FALL, fe);
      wreg(`PCEI_OFS_CTRL, {7'h00, men});
      wreg(`PCEI_OFS_MASK, 8'h01);
      nw   = (i == 0) ? 8'hFF : 8'(rnd());
      e    = edges(want, nw, re, fe);
      flg  = flg | e;
      st   = st | (|e);
      dly  <= 4'(rnd() & 32'h3);
      want <= nw;
      settle();
      chk(irq, men & st);
      rreg(`PCEI_OFS_FLAG, d);
      chk(d, flg);
      rreg(`PCEI_OFS_CTRL, d);
      chk(d, {6'h00, |flg, men});
      rreg(`PCEI_OFS_STAT, d);
      chk(d, {7'h00, st});
      st = 1'b0;
      chk(irq, 1'b0);
      if (i % 4 == 3)
      begin
        // Clear only the flags that were seen set
        rreg(`PCEI_OFS_FLAG, d);
        wreg(`PCEI_OFS_FLAG, ~d);
        rreg(`PCEI_OFS_FLAG, d);
        chk(d, 8'h00);
        flg = 8'h00;
      end
    end
    // Clearing write landing on or before a new edge leaves the flag set
    dly <= 4'h0;
    wreg(`PCEI_OFS_RISE, 8'hFF);
    wreg(`PCEI_OFS_FALL, 8'hFF);
    for (int off = 0; off < 3; off++)
    begin
      wreg(`PCEI_OFS_FLAG, 8'h00);
      want <= want ^ 8'h01;
      repeat (off) @(posedge clk_i);
      wreg(`PCEI_OFS_FLAG, 8'h00);
      settle();
      rreg(`PCEI_OFS_FLAG, d);
      chk(d, 8'h01);
    end
    // Sleep without master enable: flag set, no wake
    wreg(`PCEI_OFS_FLAG, 8'h00);
    rreg(`PCEI_OFS_STAT, d);
    wreg(`PCEI_OFS_CTRL, 8'h04);
    want <= want ^ 8'h02;
    settle();
    chk(slp, 1'b1);
    chk(irq, 1'b0);
    rreg(`PCEI_OFS_FLAG, d);
    chk(d, 8'h02);
    // Sleep with master enable: an edge wakes, flags already updated
    wreg(`PCEI_OFS_FLAG, 8'h00);
    wreg(`PCEI_OFS_MASK, 8'h02);
    wreg(`PCEI_OFS_CTRL, 8'h05);
    want <= want ^ 8'h04;
    for (int k = 0; k <= 20; k++)
    begin
      @(posedge clk_i);
      #1;
      if (wake === 1'b1)
        break;
      if (k == 20)
      begin
        failures++;
        report_and_stop();
      end
    end
    chk(slp, 1'b0);
    chk(irq, 1'b1);
    rreg(`PCEI_OFS_FLAG, d);
    chk(d, 8'h04);
    rreg(`PCEI_OFS_STAT, d);
    chk(d, 8'h03);
    report_and_stop();
  end
endmodule
